/* core/wfcd_core.sv */
/*
  write-family command decoder: takes write, read, mark-invalid and
  zero-fill commands, tracks per-block state and posts one completion each.
  assumes commands arrive synchronous to clk_i and the media side returns
  commit_done_i after commit_req_o.
*/
// What this block does
// - every finished command posts one completion
// - write errors: 80h, 81h, 82h
// - zero-fill errors: only 81h and 82h
// - reads of marked blocks fail unrecovered
// - a write clears the invalid marking
// - mark-invalid uses only dwords 10-12
// - start address from dwords 10 and 11
// - count is dword 12 low, plus one
// - zero-filled blocks read back zeroes
// - zero-fill zeroes metadata, applies protection action
// - zero-fill decodes dwords 10,11,12,14,15
// - bit 31 selects limited retry
// - bit 30 commits to media before completing
// - reference tag from dword 14 if protected
// - app tag mask/value from dword 15
`timescale 1ns/1ps
`default_nettype none
module wfcd_core
  import wfcd_pkg::*;
#(
  parameter int NUM_BLOCKS = 64
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cmd_valid_i,
  input  wire wfcd_cmd_t   cmd_i,
  output var  logic        cmd_ready_o,
  output var  wfcd_cqe_t   cqe_o,
  output var  wfcd_media_t media_o,
  output var  logic        commit_req_o,
  input  wire logic        commit_done_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output var  logic [31:0] reg_rdata_o
);
  localparam int IW = $clog2(NUM_BLOCKS);
  localparam logic [63:0] LAST_BLK = 64'(NUM_BLOCKS - 1);

  typedef struct packed {
    wfcd_st_t    st;
    wfcd_cmd_t   cmd;
    logic [63:0] cur;
    logic [15:0] left;
    logic [16:0] walked;
    logic        bad_read;
    logic        all_zero;
    logic [2:0]  sct;
    logic [7:0]  sc;
    logic        ready;
    wfcd_cqe_t   cqe;
    wfcd_media_t media;
    logic        commit_req;
    logic [31:0] ctrl;
    logic [63:0] ro_lo;
    logic [63:0] ro_hi;
    logic [31:0] count;
    logic [31:0] rdata;
  } wfcd_state_t;

  wfcd_state_t s_reg;
  wfcd_state_t s_next;
  wfcd_blk_t   blk_mem [NUM_BLOCKS];
  logic          mem_we;
  logic [IW-1:0] mem_idx;
  wfcd_blk_t     mem_val;

  // ---------------------------------------------------------------
  // field decode of the latched command
  // ---------------------------------------------------------------
  logic [63:0] start_blk;
  logic [15:0] cnt_m1;
  logic [63:0] end_blk;
  logic        is_write;
  logic        is_read;
  logic        is_mark;
  logic        is_zero;
  logic        pi_on;
  logic        ro_hit;

  // start and end of the addressed range; reserved count bits never reach the walk
  assign start_blk = {s_reg.cmd.dw11, s_reg.cmd.dw10};
  assign cnt_m1    = s_reg.cmd.dw12[WFCD_D12_CNT_HI:0];
  assign end_blk   = start_blk + {48'h0000_0000_0000, cnt_m1};
  assign is_write  = s_reg.cmd.opcode == WFCD_OP_WRITE;
  assign is_read   = s_reg.cmd.opcode == WFCD_OP_READ;
  assign is_mark   = s_reg.cmd.opcode == WFCD_OP_MARKBAD;
  assign is_zero   = s_reg.cmd.opcode == WFCD_OP_ZFILL;
  assign pi_on     = s_reg.ctrl[0];
  assign ro_hit    = s_reg.ctrl[1] && !(end_blk < s_reg.ro_lo) && !(start_blk > s_reg.ro_hi);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // command engine, media strobe and register file in one pass
  always_comb begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_idx = s_reg.cur[IW-1:0];
    mem_val = WFCD_BLK_OK;
    s_next.cqe.valid = 1'b0;
    s_next.media.valid = 1'b0;
    s_next.rdata = 32'h0000_0000;
    case (s_reg.st)
      WFCD_IDLE: begin
        // a command is taken only while the port shows ready
        if (cmd_valid_i && s_reg.ready) begin
          s_next.cmd = cmd_i;
          s_next.ready = 1'b0;
          s_next.st = WFCD_CHECK;
        end
      end
      WFCD_CHECK: begin
        s_next.sct = WFCD_SCT_CMD;
        s_next.sc = WFCD_SC_OK;
        s_next.st = WFCD_DONE;
        s_next.bad_read = 1'b0;
        s_next.all_zero = 1'b1;
        s_next.walked = 17'h0_0000;
        // first failing check wins; a failed command leaves its blocks untouched
        if (!(is_write || is_read || is_mark || is_zero)) begin
          s_next.sct = WFCD_SCT_GEN;
          s_next.sc = WFCD_SC_BADOP;
        end else if (is_write && s_reg.cmd.conflict) begin
          s_next.sc = WFCD_SC_CONFL;
        end else if ((is_write || is_zero) && (s_reg.cmd.bad_pi ||
                     (is_zero && s_reg.cmd.dw12[WFCD_D12_PA_LO+2:WFCD_D12_PA_LO] != 3'b000))) begin
          s_next.sc = WFCD_SC_BADPI;
        end else if ((is_write || is_zero) && ro_hit) begin
          s_next.sc = WFCD_SC_RDONLY;
        end else if (end_blk > LAST_BLK || end_blk < start_blk) begin
          s_next.sct = WFCD_SCT_GEN;
          s_next.sc = WFCD_SC_RANGE;
        end else begin
          s_next.sct = WFCD_SCT_GEN;
          s_next.cur = start_blk;
          s_next.left = cnt_m1;
          s_next.st = WFCD_WALK;
        end
      end
      WFCD_WALK: begin
        // one block per cycle, count+1 blocks in all
        s_next.walked = s_reg.walked + 17'h0_0001;
        s_next.cur = s_reg.cur + 64'h0000_0000_0000_0001;
        s_next.left = s_reg.left - 16'h0001;
        s_next.media.valid = !is_read;
        s_next.media.block = s_reg.cur;
        s_next.media.opcode = s_reg.cmd.opcode;
        s_next.media.limited_retry = is_zero && s_reg.cmd.dw12[WFCD_D12_RETRY];
        s_next.media.meta_zero = is_zero;
        s_next.media.protection_action_field =
          is_zero ? s_reg.cmd.dw12[WFCD_D12_PA_HI:WFCD_D12_PA_LO] : 4'h0;
        s_next.media.initial_reference_tag = (is_zero && pi_on) ? s_reg.cmd.dw14 : 32'h0000_0000;
        s_next.media.app_tag_mask  = (is_zero && pi_on) ? s_reg.cmd.dw15[31:16] : 16'h0000;
        s_next.media.app_tag_value = (is_zero && pi_on) ? s_reg.cmd.dw15[15:0] : 16'h0000;
        mem_we = !is_read;
        if (is_write) begin
          mem_val = WFCD_BLK_OK;
        end else if (is_mark) begin
          mem_val = WFCD_BLK_BAD;
        end else begin
          mem_val = WFCD_BLK_ZERO;
        end
        if (is_read && blk_mem[s_reg.cur[IW-1:0]] == WFCD_BLK_BAD) begin
          s_next.bad_read = 1'b1;
        end
        if (blk_mem[s_reg.cur[IW-1:0]] != WFCD_BLK_ZERO) begin
          s_next.all_zero = 1'b0;
        end
        if (s_reg.left == 16'h0000) begin
          if (is_zero && s_reg.cmd.dw12[WFCD_D12_COMMIT]) begin
            s_next.commit_req = 1'b1;
            s_next.st = WFCD_COMMIT;
          end else begin
            s_next.st = WFCD_DONE;
          end
        end
      end
      WFCD_COMMIT: begin
        // completion held back until the media confirms the commit
        if (commit_done_i) begin
          s_next.commit_req = 1'b0;
          s_next.st = WFCD_DONE;
        end
      end
      WFCD_DONE: begin
        s_next.cqe.valid = 1'b1;
        s_next.cqe.cid = s_reg.cmd.cid;
        s_next.cqe.cqid = s_reg.cmd.cqid;
        s_next.cqe.sct = s_reg.bad_read ? WFCD_SCT_MEDIA : s_reg.sct;
        s_next.cqe.sc = s_reg.bad_read ? WFCD_SC_UNREC : s_reg.sc;
        s_next.cqe.zero_data = is_read && !s_reg.bad_read && s_reg.all_zero
                               && s_reg.sc == WFCD_SC_OK;
        // ready returns with the completion so the next command may be taken at once
        s_next.count = s_reg.count + 32'h0000_0001;
        s_next.ready = 1'b1;
        s_next.st = WFCD_IDLE;
      end
      default: begin
        s_next.st = WFCD_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        WFCD_REG_CTRL:  s_next.ctrl = {30'h0000_0000, reg_wdata_i[1:0]};
        WFCD_REG_RO_LO: s_next.ro_lo = {32'h0000_0000, reg_wdata_i};
        WFCD_REG_RO_HI: s_next.ro_hi = {32'h0000_0000, reg_wdata_i};
        default: begin
        end
      endcase
    end
    // register reads, answered in the next cycle only
    if (reg_rd_i) begin
      case (reg_addr_i)
        WFCD_REG_CTRL:   s_next.rdata = s_reg.ctrl;
        WFCD_REG_RO_LO:  s_next.rdata = s_reg.ro_lo[31:0];
        WFCD_REG_RO_HI:  s_next.rdata = s_reg.ro_hi[31:0];
        WFCD_REG_STATUS: s_next.rdata = {17'h0_0000, ~s_reg.ready, s_reg.st, s_reg.cqe.sct, s_reg.cqe.sc};
        WFCD_REG_COUNT:  s_next.rdata = s_reg.count;
        default:         s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state and block table registers
  // ---------------------------------------------------------------
  // one register stage for the whole state record
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
      s_reg.st <= WFCD_IDLE;
      s_reg.ready <= 1'b1;
      s_reg.ctrl <= WFCD_CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // block table clears to plain state on reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        blk_mem[i] <= WFCD_BLK_OK;
      end
    end else if (mem_we) begin
      blk_mem[mem_idx] <= mem_val;
    end
  end

  assign cmd_ready_o  = s_reg.ready;
  assign cqe_o        = s_reg.cqe;
  assign media_o      = s_reg.media;
  assign commit_req_o = s_reg.commit_req;
  assign reg_rdata_o  = s_reg.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_CQE_POSTED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_reg.st == WFCD_CHECK |-> ##[1:300] cqe_o.valid)
    else $error("command finished without a completion");
  AST_WRITE_CONFLICT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_CHECK && is_write && s_reg.cmd.conflict) |-> ##2 (cqe_o.valid && cqe_o.sc == 8'h80))
    else $error("conflicting write not reported as 80h");
  AST_ZFILL_NO_CONFLICT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cqe_o.valid && is_zero && cqe_o.sct == WFCD_SCT_CMD) |-> cqe_o.sc != 8'h80)
    else $error("zero-fill reported conflicting attributes");
  AST_READ_MARKED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_read && blk_mem[s_reg.cur[IW-1:0]] == WFCD_BLK_BAD)
    |-> ##[2:300] (cqe_o.valid && cqe_o.sct == WFCD_SCT_MEDIA && cqe_o.sc == 8'h81))
    else $error("read of marked block did not fail");
  AST_WRITE_CLEARS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_write) |=> blk_mem[$past(s_reg.cur[IW-1:0])] == WFCD_BLK_OK)
    else $error("write left block marked");
  AST_START_FROM_DW: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(s_reg.st == WFCD_WALK) |-> s_reg.cur == {s_reg.cmd.dw11, s_reg.cmd.dw10})
    else $error("walk did not start at dword 11:10");
  AST_COUNT_PLUS_ONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(s_reg.st == WFCD_WALK) |-> s_reg.walked == {1'b0, cnt_m1} + 17'h0_0001)
    else $error("walk length not count plus one");
  AST_ZFILL_MARKS_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_zero) |=> blk_mem[$past(s_reg.cur[IW-1:0])] == WFCD_BLK_ZERO)
    else $error("zero-fill did not record zeroed block");
  AST_COMMIT_BEFORE_DONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (commit_req_o && !commit_done_i) |=> (!cqe_o.valid && s_reg.st == WFCD_COMMIT))
    else $error("completion before media commit");
  AST_TAGS_GATED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (media_o.valid && !$past(pi_on)) |-> (media_o.initial_reference_tag == 32'h0000_0000
                                         && media_o.app_tag_mask == 16'h0000
                                         && media_o.app_tag_value == 16'h0000))
    else $error("protection tags passed without protection format");
  // completion pulse is one cycle wide and frees the port at once
  AST_ONE_CQE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cqe_o.valid |=> !cqe_o.valid)
    else $error("completion pulse longer than one cycle");
  AST_READY_AFTER_CQE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cqe_o.valid |-> cmd_ready_o)
    else $error("port still busy while completion posts");
  // command-specific codes per opcode
  AST_WRITE_BADPI: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_CHECK && is_write && !s_reg.cmd.conflict && s_reg.cmd.bad_pi)
    |-> ##2 (cqe_o.valid && cqe_o.sct == WFCD_SCT_CMD && cqe_o.sc == 8'h81))
    else $error("bad protection write not reported as 81h");
  AST_WRITE_RDONLY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_CHECK && is_write && !s_reg.cmd.conflict && !s_reg.cmd.bad_pi && ro_hit)
    |-> ##2 (cqe_o.valid && cqe_o.sct == WFCD_SCT_CMD && cqe_o.sc == 8'h82))
    else $error("write into read-only window not reported as 82h");
  AST_ZFILL_CODES: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cqe_o.valid && is_zero && cqe_o.sct == WFCD_SCT_CMD) |-> (cqe_o.sc == 8'h81 || cqe_o.sc == 8'h82))
    else $error("zero-fill reported a code other than 81h or 82h");
  // block table and walk bounds
  AST_MARK_SETS_BAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_mark) |=> blk_mem[$past(s_reg.cur[IW-1:0])] == WFCD_BLK_BAD)
    else $error("mark-invalid did not mark block");
  AST_WALK_IN_RANGE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_reg.st == WFCD_WALK |-> s_reg.cur <= LAST_BLK)
    else $error("walk left the block table");
  // media strobe contents for zero-fill
  AST_ZFILL_META: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_zero) |=> (media_o.valid && media_o.meta_zero
      && media_o.protection_action_field == s_reg.cmd.dw12[WFCD_D12_PA_HI:WFCD_D12_PA_LO]))
    else $error("zero-fill strobe lacks zero metadata or action");
  AST_ZFILL_RETRY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_zero) |=> media_o.limited_retry == s_reg.cmd.dw12[WFCD_D12_RETRY])
    else $error("limited retry not passed on");
  AST_TAGS_PASSED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st == WFCD_WALK && is_zero && pi_on) |=> (media_o.initial_reference_tag == s_reg.cmd.dw14
      && media_o.app_tag_mask == s_reg.cmd.dw15[31:16] && media_o.app_tag_value == s_reg.cmd.dw15[15:0]))
    else $error("protection tags not passed from dwords 14 and 15");
endmodule
`default_nettype wire

/* core/wfcd_pkg.sv */
/*
  package for the write-family command decoder: command and completion
  carriers, opcodes, status codes, register offsets and field positions.
  assumes the importing module runs on one clock with a synchronous reset.
*/
package wfcd_pkg;
  // ---------------------------------------------------------------
  // opcodes, status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] WFCD_OP_WRITE   = 8'h01;
  localparam logic [7:0] WFCD_OP_READ    = 8'h02;
  localparam logic [7:0] WFCD_OP_MARKBAD = 8'h04;
  localparam logic [7:0] WFCD_OP_ZFILL   = 8'h08;
  localparam logic [2:0] WFCD_SCT_GEN    = 3'h0;
  localparam logic [2:0] WFCD_SCT_CMD    = 3'h1;
  localparam logic [2:0] WFCD_SCT_MEDIA  = 3'h2;
  localparam logic [7:0] WFCD_SC_OK      = 8'h00;
  localparam logic [7:0] WFCD_SC_BADOP   = 8'h01;
  localparam logic [7:0] WFCD_SC_RANGE   = 8'h80;
  localparam logic [7:0] WFCD_SC_CONFL   = 8'h80;
  localparam logic [7:0] WFCD_SC_BADPI   = 8'h81;
  localparam logic [7:0] WFCD_SC_RDONLY  = 8'h82;
  localparam logic [7:0] WFCD_SC_UNREC   = 8'h81;
  // ---------------------------------------------------------------
  // dword 12 fields, register map
  // ---------------------------------------------------------------
  localparam int WFCD_D12_RETRY  = 31;
  localparam int WFCD_D12_COMMIT = 30;
  localparam int WFCD_D12_PA_HI  = 29;
  localparam int WFCD_D12_PA_LO  = 26;
  localparam int WFCD_D12_CNT_HI = 15;
  localparam logic [7:0] WFCD_REG_CTRL   = 8'h00;
  localparam logic [7:0] WFCD_REG_RO_LO  = 8'h04;
  localparam logic [7:0] WFCD_REG_RO_HI  = 8'h08;
  localparam logic [7:0] WFCD_REG_STATUS = 8'h0C;
  localparam logic [7:0] WFCD_REG_COUNT  = 8'h10;
  localparam logic [31:0] WFCD_CTRL_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {WFCD_BLK_OK, WFCD_BLK_BAD, WFCD_BLK_ZERO} wfcd_blk_t;
  typedef enum logic [2:0] {WFCD_IDLE, WFCD_CHECK, WFCD_WALK, WFCD_COMMIT, WFCD_DONE} wfcd_st_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] cid;
    logic [15:0] cqid;
    logic [31:0] dw10;
    logic [31:0] dw11;
    logic [31:0] dw12;
    logic [31:0] dw14;
    logic [31:0] dw15;
    logic        conflict;
    logic        bad_pi;
  } wfcd_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] cid;
    logic [15:0] cqid;
    logic [2:0]  sct;
    logic [7:0]  sc;
    logic        zero_data;
  } wfcd_cqe_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] block;
    logic [7:0]  opcode;
    logic        limited_retry;
    logic        meta_zero;
    logic [3:0]  protection_action_field;
    logic [31:0] initial_reference_tag;
    logic [15:0] app_tag_mask;
    logic [15:0] app_tag_value;
  } wfcd_media_t;
endpackage

/* verif/tb_top.sv */
/*
  self-checking bench for the write-family decoder: register and command
  tasks, status and media checks, media partner for commits.
  assumes wfcd_pkg is compiled first and a small block table.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wfcd_pkg::*;
  localparam int NB    = 8;
  localparam int LIMIT = 5000;
  logic        clk_i, sys_rst_i, cmd_valid_i, reg_wr_i, reg_rd_i;
  logic        cmd_ready_o, commit_req_o, commit_done_i;
  logic [7:0]  reg_addr_i, delay, commit_cnt;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] cid_n;
  wfcd_cmd_t   cmd_i;
  wfcd_cqe_t   cqe_o;
  wfcd_media_t media_o, first_media, last_media;
  int          miscompares = 0, check_count = 0, media_cnt = 0, cycles = 0, media_base = 0;

  wfcd_core #(.NUM_BLOCKS(NB)) wfcd_core_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cqe_o(cqe_o),
    .media_o(media_o), .commit_req_o(commit_req_o), .commit_done_i(commit_done_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  wfcd_media_model wfcd_media_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .commit_req_i(commit_req_o), .delay_i(delay), .commit_done_o(commit_done_i),
    .commit_cnt_o(commit_cnt));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // monitors and shared tasks
  // ---------------------------------------------------------------
  // media pulse capture and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (media_o.valid === 1'b1) begin
      if (media_cnt == media_base) first_media <= media_o;
      last_media <= media_o;
      media_cnt  <= media_cnt + 1;
    end
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 check(reg_rdata_o, exp);
  endtask

  // offer one command, wait for its completion, compare identity and status
  task automatic issue(input logic [7:0] op, input logic [63:0] blk, input logic [31:0] d12,
                       input logic cf, input logic bp, input logic [2:0] sct, input logic [7:0] sc);
    int n;
    n = 0;
    media_base = media_cnt;
    cid_n = cid_n + 16'h0001;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{opcode: op, cid: cid_n, cqid: ~cid_n, dw10: blk[31:0], dw11: blk[63:32], dw12: d12,
               dw14: 32'hA5A5_0001, dw15: 32'hF0F0_1234, conflict: cf, bad_pi: bp};
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (cqe_o.valid !== 1'b1 && n < 200);
    if (n >= 200) miscompares++;
    check({cqe_o.cid, cqe_o.cqid, cqe_o.sct, cqe_o.sc}, {cid_n, ~cid_n, sct, sc});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    delay = 8'h14;
    cid_n = 16'h0000;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    reg_wr(WFCD_REG_CTRL, 32'h0000_0002);
    reg_wr(WFCD_REG_RO_LO, 32'h0000_0006);
    reg_wr(WFCD_REG_RO_HI, 32'h0000_0006);
    reg_rd(WFCD_REG_CTRL, 32'h0000_0002);
    reg_rd(8'h20, 32'h0000_0000);
    reg_wr(8'h20, 32'hFFFF_FFFF);
    reg_rd(WFCD_REG_RO_LO, 32'h0000_0006);
    reg_rd(WFCD_REG_RO_HI, 32'h0000_0006);
    // marking two blocks with reserved high bits set
    issue(WFCD_OP_MARKBAD, 64'h3, 32'hFFFF_0001, 1'b1, 1'b1, WFCD_SCT_GEN, WFCD_SC_OK);
    check(media_cnt - media_base, 2);
    check(first_media.block, 64'h3);
    issue(WFCD_OP_READ, 64'h3, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_MEDIA, WFCD_SC_UNREC);
    issue(WFCD_OP_READ, 64'h4, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_MEDIA, WFCD_SC_UNREC);
    issue(WFCD_OP_READ, 64'h5, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    issue(WFCD_OP_WRITE, 64'h3, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    issue(WFCD_OP_READ, 64'h3, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    issue(WFCD_OP_MARKBAD, 64'h1_0000_0000, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_RANGE);
    issue(WFCD_OP_MARKBAD, 64'h7, 32'h0000_0001, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_RANGE);
    // write faults: conflict, bad protection, read-only block
    for (int i = 0; i < 3; i++) begin
      issue(WFCD_OP_WRITE, (i == 2) ? 64'h6 : 64'h0, 32'h0000_0000, i == 0, i == 1,
            WFCD_SCT_CMD, 8'h80 + 8'(i));
    end
    // zero-fill faults never report a conflict, even when one is flagged
    for (int i = 0; i < 3; i++) begin
      issue(WFCD_OP_ZFILL, (i == 2) ? 64'h6 : 64'h0, (i == 0) ? 32'h0400_0000 : 32'h0000_0000,
            1'b1, i == 1, WFCD_SCT_CMD, (i == 2) ? WFCD_SC_RDONLY : WFCD_SC_BADPI);
    end
    check(media_cnt - media_base, 0);
    // unprotected zero-fill, no forced commit: tags stay clear
    issue(WFCD_OP_ZFILL, 64'h2, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    check(commit_cnt, 8'h00);
    check({last_media.limited_retry, last_media.initial_reference_tag, last_media.app_tag_mask,
           last_media.app_tag_value}, 65'h0);
    // protected zero-fill with retry, commit, action 1000b, reserved bits set
    reg_wr(WFCD_REG_CTRL, 32'h0000_0003);
    issue(WFCD_OP_ZFILL, 64'h0, 32'hE3FF_0001, 1'b1, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    check(commit_cnt, 8'h01);
    check(media_cnt - media_base, 2);
    check(last_media.block, 64'h1);
    check({last_media.meta_zero, last_media.limited_retry, last_media.protection_action_field},
          6'b11_1000);
    check({last_media.initial_reference_tag, last_media.app_tag_mask, last_media.app_tag_value},
          64'hA5A5_0001_F0F0_1234);
    issue(WFCD_OP_READ, 64'h0, 32'h0000_0001, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    check(cqe_o.zero_data, 1'b1);
    issue(WFCD_OP_READ, 64'h2, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    check(cqe_o.zero_data, 1'b1);
    issue(WFCD_OP_WRITE, 64'h0, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    issue(WFCD_OP_READ, 64'h0, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    check(cqe_o.zero_data, 1'b0);
    // mark-invalid with protection on: the spare dwords must not reach the media
    issue(WFCD_OP_MARKBAD, 64'h5, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_OK);
    check({last_media.opcode, last_media.meta_zero, last_media.initial_reference_tag, last_media.app_tag_mask,
           last_media.app_tag_value}, {WFCD_OP_MARKBAD, 65'h0});
    issue(8'h7E, 64'h0, 32'h0000_0000, 1'b0, 1'b0, WFCD_SCT_GEN, WFCD_SC_BADOP);
    reg_rd(WFCD_REG_COUNT, {16'h0000, cid_n});
    reg_rd(WFCD_REG_STATUS, 32'h0000_0001);
    summarize();
  end
endmodule
`default_nettype wire

/* verif/wfcd_media_model.sv */
/*
  media-side partner for the write-family decoder: answers each commit
  request with a one-cycle acknowledge after a programmable wait.
  assumes it shares clk_i and the synchronous reset with the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module wfcd_media_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       commit_req_i,
  input  wire logic [7:0] delay_i,
  output var  logic       commit_done_o,
  output var  logic [7:0] commit_cnt_o
);
  logic [7:0] wait_reg;
  logic       held_reg;

  // one acknowledge per request, held off until the request drops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_reg      <= 8'h00;
      held_reg      <= 1'b0;
      commit_done_o <= 1'b0;
      commit_cnt_o  <= 8'h00;
    end else begin
      commit_done_o <= 1'b0;
      if (!commit_req_i) begin
        wait_reg <= 8'h00;
        held_reg <= 1'b0;
      end else if (!held_reg && wait_reg >= delay_i) begin
        commit_done_o <= 1'b1;
        held_reg      <= 1'b1;
        commit_cnt_o  <= commit_cnt_o + 8'h01;
      end else begin
        wait_reg <= wait_reg + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
